// ---- pcseq_defines.svh ----
// Functional notes
// - adding an offset to the pc low byte performs a computed jump
// - return stack holds eight entries of thirteen bits each
// - stack is outside program and data space; pointer is hidden
// - call or interrupt vector pushes the pc plus one
// - return, return with literal or interrupt return pops into pc
// - push and pop leave the pc high latch unchanged
// - stack is circular; ninth push overwrites the first entry
// - no overflow or underflow indication; wrapping is silent
// - pc addresses a contiguous program space of 8K words
// - call and jump give 11 bits; page bits come from latch bits 4:3
// - returns restore all 13 pc bits regardless of latch page bits
// - indirect data port is not physical; it accesses pointer location
// - reading the indirect port through itself returns zero
// - writing the indirect port through itself stores nothing
// - indirect address is bank bit above the 8-bit file select pointer
// - any reset clears the whole program counter
// - writing the pc low byte loads pc high from latch bits 4:0
`ifndef PCSEQ_DEFINES_SVH
`define PCSEQ_DEFINES_SVH
`define PC_WIDTH        13
`define PTR_WIDTH       3
`define STACK_DEPTH     8
`define JUMP_BITS       11
`define PAGE_LSB        3
`define PAGE_MSB        4
`define HIGH_LSB        0
`define HIGH_MSB        4
`define DADDR_WIDTH     9
`define PC_LOW_ADDR     7'h02
`define INDIRECT_ADDR   7'h00
`define LATCH_ADDR      7'h0a
`define POINTER_ADDR    7'h04
`define PC_RESET        13'h0000
`define LATCH_RESET     8'h00
`define POINTER_RESET   8'h00
`endif

// ---- pcseq_pkg.sv ----
package pcseq_pkg;
	typedef enum logic [2:0] {
		PC_NONE = 3'h0,
		PC_STEP = 3'h1,
		PC_JUMP = 3'h2,
		PC_CALL = 3'h3,
		PC_VECT = 3'h4,
		PC_RET  = 3'h5
	} pc_op_t;
	typedef logic [12:0] pc_t;
endpackage

// ---- pc_stack_indirect_addr.sv ----
`include "pcseq_defines.svh"
module pc_stack_indirect_addr (
	input  wire logic            I_CLK_SYS,
	input  wire logic            I_SRST,
	input  wire pcseq_pkg::pc_op_t I_PC_OP,
	input  wire logic [10:0]     I_JUMP_ADDR,
	input  wire logic [12:0]     I_VECTOR_ADDR,
	input  wire logic            I_FILE_WR,
	input  wire logic            I_FILE_RD,
	input  wire logic [6:0]      I_FILE_ADDR,
	input  wire logic [7:0]      I_FILE_WDATA,
	input  wire logic            I_BANK_BIT,
	input  wire logic [7:0]      I_RAM_RDATA,
	output logic [12:0]          O_PC,
	output logic [7:0]           O_FILE_RDATA,
	output logic [8:0]           O_RAM_ADDR,
	output logic                 O_RAM_WR,
	output logic [7:0]           O_RAM_WDATA,
	output logic [7:0]           O_PC_HIGH_LATCH
);
	import pcseq_pkg::*;

	// eight 13-bit entries, no address in program or data space
	pc_t        stack_mem [`STACK_DEPTH];
	logic [2:0] stack_ptr_reg;
	pc_t        pc_reg;
	logic [7:0] pc_high_latch_reg;
	logic [7:0] file_select_pointer_reg;
	logic [7:0] file_select_pointer_next;
	pc_t        pc_next;
	pc_t        pop_value;
	logic [2:0] pop_ptr;
	logic       self_ref;
	logic [8:0] ind_addr;

	function automatic logic hits(input logic [6:0] a, input logic [6:0] target);
		hits = (a == target);
	endfunction

	assign pop_ptr = stack_ptr_reg - 3'h1;
	assign pop_value = stack_mem[pop_ptr];
	// forwarded so an indirect access right after a pointer write sees the new cell
	assign file_select_pointer_next = (I_FILE_WR && hits(I_FILE_ADDR, `POINTER_ADDR)) ?
		I_FILE_WDATA : file_select_pointer_reg;
	assign ind_addr = {I_BANK_BIT, file_select_pointer_next};
	assign self_ref = (file_select_pointer_reg[6:0] == `INDIRECT_ADDR);

	always_comb begin
		pc_next = pc_reg + 13'h0001;
		case (I_PC_OP)
			PC_JUMP, PC_CALL: pc_next = {pc_high_latch_reg[`PAGE_MSB:`PAGE_LSB], I_JUMP_ADDR};
			PC_VECT: pc_next = I_VECTOR_ADDR;
			PC_RET: pc_next = pop_value;
			PC_NONE: pc_next = pc_reg;
			default: pc_next = pc_reg + 13'h0001;
		endcase
		// computed jump; high bits from latch 4:0
		if (I_FILE_WR && hits(I_FILE_ADDR, `PC_LOW_ADDR))
			pc_next = {pc_high_latch_reg[`HIGH_MSB:`HIGH_LSB], I_FILE_WDATA};
	end

	// reset clears pc; 13 bits span 8K words
	always_ff @(posedge I_CLK_SYS) begin
		if (I_SRST)
			pc_reg <= `PC_RESET;
		else
			pc_reg <= pc_next;
	end

	// push on call or vector; circular pointer, no flags
	always_ff @(posedge I_CLK_SYS) begin
		if (I_SRST) begin
			stack_ptr_reg <= 3'h0;
			for (int i = 0; i < `STACK_DEPTH; i++)
				stack_mem[i] <= `PC_RESET;
		end else if (I_PC_OP == PC_CALL || I_PC_OP == PC_VECT) begin
			stack_mem[stack_ptr_reg] <= pc_reg + 13'h0001;
			stack_ptr_reg <= stack_ptr_reg + 3'h1;
		end else if (I_PC_OP == PC_RET) begin
			stack_ptr_reg <= pop_ptr;
		end
	end

	// latch only changes by software write, never by push or pop
	always_ff @(posedge I_CLK_SYS) begin
		if (I_SRST)
			pc_high_latch_reg <= `LATCH_RESET;
		else if (I_FILE_WR && hits(I_FILE_ADDR, `LATCH_ADDR))
			pc_high_latch_reg <= I_FILE_WDATA;
	end

	// pointer lives at a fixed file slot
	always_ff @(posedge I_CLK_SYS) begin
		if (I_SRST)
			file_select_pointer_reg <= `POINTER_RESET;
		else
			file_select_pointer_reg <= file_select_pointer_next;
	end

	// indirect port redirects to ram; self-write dropped
	always_ff @(posedge I_CLK_SYS) begin
		if (I_SRST) begin
			O_RAM_WR    <= 1'b0;
			O_RAM_ADDR  <= 9'h000;
			O_RAM_WDATA <= 8'h00;
		end else begin
			O_RAM_WR    <= I_FILE_WR && hits(I_FILE_ADDR, `INDIRECT_ADDR) && !self_ref;
			O_RAM_ADDR  <= ind_addr;
			O_RAM_WDATA <= I_FILE_WDATA;
		end
	end

	// read data stand only in the cycle after the strobe; ram answers on O_RAM_ADDR
	always_ff @(posedge I_CLK_SYS) begin
		if (I_SRST || !I_FILE_RD)
			O_FILE_RDATA <= 8'h00;
		else if (hits(I_FILE_ADDR, `PC_LOW_ADDR))
			O_FILE_RDATA <= pc_reg[7:0];
		else if (hits(I_FILE_ADDR, `LATCH_ADDR))
			O_FILE_RDATA <= pc_high_latch_reg;
		else if (hits(I_FILE_ADDR, `POINTER_ADDR))
			O_FILE_RDATA <= file_select_pointer_reg;
		// self-read gives zero; otherwise the pointed ram cell
		else if (hits(I_FILE_ADDR, `INDIRECT_ADDR))
			O_FILE_RDATA <= self_ref ? 8'h00 : I_RAM_RDATA;
		else
			O_FILE_RDATA <= 8'h00;
	end

	assign O_PC = pc_reg;
	assign O_PC_HIGH_LATCH = pc_high_latch_reg;

	pc_reset_a: assert property (
		@(posedge I_CLK_SYS)
		I_SRST
		|=> O_PC == `PC_RESET
	) else begin
		$error("pc not cleared by reset");
	end

	ptr_reset_a: assert property (
		@(posedge I_CLK_SYS)
		I_SRST
		|=> stack_ptr_reg == 3'h0
	) else begin
		$error("stack pointer not cleared by reset");
	end

	page_jump_a: assert property (
		@(posedge I_CLK_SYS) disable iff (I_SRST)
		I_PC_OP == PC_JUMP && !I_FILE_WR
		|=> O_PC == {$past(pc_high_latch_reg[`PAGE_MSB:`PAGE_LSB]), $past(I_JUMP_ADDR)}
	) else begin
		$error("jump page wrong");
	end

	page_call_a: assert property (
		@(posedge I_CLK_SYS) disable iff (I_SRST)
		I_PC_OP == PC_CALL && !I_FILE_WR
		|=> O_PC == {$past(pc_high_latch_reg[`PAGE_MSB:`PAGE_LSB]), $past(I_JUMP_ADDR)}
	) else begin
		$error("call page wrong");
	end

	vector_target_a: assert property (
		@(posedge I_CLK_SYS) disable iff (I_SRST)
		I_PC_OP == PC_VECT && !I_FILE_WR
		|=> O_PC == $past(I_VECTOR_ADDR)
	) else begin
		$error("vector target wrong");
	end

	call_ret_a: assert property (
		@(posedge I_CLK_SYS) disable iff (I_SRST)
		(I_PC_OP == PC_CALL && !I_FILE_WR)
		##1 (I_PC_OP == PC_RET && !I_FILE_WR)
		|=> O_PC == $past(O_PC, 2) + 13'h0001
	) else begin
		$error("return address wrong");
	end

	ret_restore_a: assert property (
		@(posedge I_CLK_SYS) disable iff (I_SRST)
		I_PC_OP == PC_RET && !I_FILE_WR
		|=> O_PC == $past(pop_value)
	) else begin
		$error("return not restored from stack");
	end

	push_value_a: assert property (
		@(posedge I_CLK_SYS) disable iff (I_SRST)
		I_PC_OP inside {PC_CALL, PC_VECT}
		|=> stack_mem[$past(stack_ptr_reg)] == $past(pc_reg) + 13'h0001
	) else begin
		$error("pushed value wrong");
	end

	push_wrap_a: assert property (
		@(posedge I_CLK_SYS) disable iff (I_SRST)
		I_PC_OP inside {PC_CALL, PC_VECT}
		|=> stack_ptr_reg == $past(stack_ptr_reg) + 3'h1
	) else begin
		$error("push pointer step wrong");
	end

	pop_wrap_a: assert property (
		@(posedge I_CLK_SYS) disable iff (I_SRST)
		I_PC_OP == PC_RET
		|=> stack_ptr_reg == $past(stack_ptr_reg) - 3'h1
	) else begin
		$error("pop pointer step wrong");
	end

	// pointer moves only by stack ops
	ptr_hidden_a: assert property (
		@(posedge I_CLK_SYS) disable iff (I_SRST)
		!(I_PC_OP inside {PC_CALL, PC_VECT, PC_RET})
		|=> $stable(stack_ptr_reg)
	) else begin
		$error("stack pointer moved without stack op");
	end

	latch_keep_a: assert property (
		@(posedge I_CLK_SYS) disable iff (I_SRST)
		I_PC_OP inside {PC_CALL, PC_RET} && !I_FILE_WR
		|=> $stable(O_PC_HIGH_LATCH)
	) else begin
		$error("latch changed by stack op");
	end

	// latch changes only by its write
	latch_only_sw_a: assert property (
		@(posedge I_CLK_SYS) disable iff (I_SRST)
		!(I_FILE_WR && I_FILE_ADDR == `LATCH_ADDR)
		|=> $stable(O_PC_HIGH_LATCH)
	) else begin
		$error("latch changed without write");
	end

	latch_load_a: assert property (
		@(posedge I_CLK_SYS) disable iff (I_SRST)
		I_FILE_WR && I_FILE_ADDR == `LATCH_ADDR
		|=> O_PC_HIGH_LATCH == $past(I_FILE_WDATA)
	) else begin
		$error("latch write lost");
	end

	pc_step_a: assert property (
		@(posedge I_CLK_SYS) disable iff (I_SRST)
		I_PC_OP == PC_STEP && !I_FILE_WR
		|=> O_PC == $past(O_PC) + 13'h0001
	) else begin
		$error("pc step wrong");
	end

	pc_hold_a: assert property (
		@(posedge I_CLK_SYS) disable iff (I_SRST)
		I_PC_OP == PC_NONE && !I_FILE_WR
		|=> $stable(O_PC)
	) else begin
		$error("pc moved while idle");
	end

	pc_low_write_a: assert property (
		@(posedge I_CLK_SYS) disable iff (I_SRST)
		I_FILE_WR && I_FILE_ADDR == `PC_LOW_ADDR
		|=> O_PC == {$past(pc_high_latch_reg[`HIGH_MSB:`HIGH_LSB]), $past(I_FILE_WDATA)}
	) else begin
		$error("low byte write load wrong");
	end

	self_write_a: assert property (
		@(posedge I_CLK_SYS) disable iff (I_SRST)
		I_FILE_WR && I_FILE_ADDR == `INDIRECT_ADDR && self_ref
		|=> !O_RAM_WR
	) else begin
		$error("self write reached ram");
	end

	self_read_a: assert property (
		@(posedge I_CLK_SYS) disable iff (I_SRST)
		I_FILE_RD && I_FILE_ADDR == `INDIRECT_ADDR && self_ref
		|=> O_FILE_RDATA == 8'h00
	) else begin
		$error("self read not zero");
	end

	ind_addr_a: assert property (
		@(posedge I_CLK_SYS) disable iff (I_SRST)
		I_FILE_WR && I_FILE_ADDR == `INDIRECT_ADDR && !self_ref
		|=> O_RAM_WR
		&& O_RAM_ADDR == {$past(I_BANK_BIT), $past(file_select_pointer_reg)}
	) else begin
		$error("indirect address wrong");
	end

	// ram written only through the port
	ram_wr_only_a: assert property (
		@(posedge I_CLK_SYS) disable iff (I_SRST)
		!(I_FILE_WR && I_FILE_ADDR == `INDIRECT_ADDR)
		|=> !O_RAM_WR
	) else begin
		$error("ram written without indirect access");
	end

	ram_wdata_a: assert property (
		@(posedge I_CLK_SYS) disable iff (I_SRST)
		I_FILE_WR && I_FILE_ADDR == `INDIRECT_ADDR && !self_ref
		|=> O_RAM_WDATA == $past(I_FILE_WDATA)
	) else begin
		$error("indirect write data wrong");
	end

	ind_read_a: assert property (
		@(posedge I_CLK_SYS) disable iff (I_SRST)
		I_FILE_RD && I_FILE_ADDR == `INDIRECT_ADDR && !self_ref
		|=> O_FILE_RDATA == $past(I_RAM_RDATA)
	) else begin
		$error("indirect read data wrong");
	end

	// a slot changes only when a push lands on it
	generate
		for (genvar g = 0; g < `STACK_DEPTH; g++) begin : slot_chk
			slot_keep_a: assert property (
				@(posedge I_CLK_SYS) disable iff (I_SRST)
				!(I_PC_OP inside {PC_CALL, PC_VECT}) || stack_ptr_reg != 3'(g)
				|=> $stable(stack_mem[g])
			) else begin
				$error("stack slot overwritten");
			end
		end
	endgenerate
endmodule

// ---- ram_model.sv ----
module ram_model (
	input  wire logic       i_clk,
	input  wire logic [8:0] i_addr,
	input  wire logic       i_wr,
	input  wire logic [7:0] i_wdata,
	output logic [7:0]      o_rdata
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] mem [512];
	// preset to the inverted low address byte, so an unwritten cell reads as zero only at 0ff and 1ff
	initial for (int i = 0; i < 512; i++) mem[i] = ~i[7:0];
	// read at the nine-bit pointer address
	assign o_rdata = mem[i_addr];
	always @(posedge i_clk) begin
		if (i_wr) mem[i_addr] <= i_wdata;
	end
endmodule

// ---- tb.sv ----
module tb;
	import pcseq_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk = 1'b0, srst = 1'b1, wr = 1'b0, rd = 1'b0, bank = 1'b0, rwr;
	pc_op_t      op = PC_NONE;
	logic [10:0] ja = '0;
	logic [12:0] va = 13'h0abc, pc;
	logic [6:0]  fa = '0;
	logic [7:0]  wd = '0, rdat, rwd, latch, rrd, d;
	logic [8:0]  ra;
	int          n_mismatch = 0, compares = 0;
	pc_stack_indirect_addr dut (.I_CLK_SYS(clk), .I_SRST(srst), .I_PC_OP(op),
		.I_JUMP_ADDR(ja), .I_VECTOR_ADDR(va), .I_FILE_WR(wr), .I_FILE_RD(rd),
		.I_FILE_ADDR(fa), .I_FILE_WDATA(wd), .I_BANK_BIT(bank), .I_RAM_RDATA(rrd),
		.O_PC(pc), .O_FILE_RDATA(rdat), .O_RAM_ADDR(ra), .O_RAM_WR(rwr),
		.O_RAM_WDATA(rwd), .O_PC_HIGH_LATCH(latch));
	ram_model ram (.i_clk(clk), .i_addr(ra), .i_wr(rwr), .i_wdata(rwd), .o_rdata(rrd));
	initial forever #5 clk = ~clk;
	task automatic chk_pc(input logic [12:0] got, input logic [12:0] exp);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: pc %h not %h", $time, got, exp);
		end
	endtask
	task automatic chk_d(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: data %h not %h", $time, got, exp);
		end
	endtask
	task automatic wr_file(input logic [6:0] a, input logic [7:0] v);
		@(posedge clk);
		fa <= a;
		wd <= v;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_file(input logic [6:0] a, output logic [7:0] v);
		@(posedge clk);
		fa <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 v = rdat;
	endtask
	task automatic do_op(input pc_op_t o, input logic [10:0] a);
		@(posedge clk);
		op <= o;
		ja <= a;
		@(posedge clk);
		op <= PC_NONE;
		#1;
	endtask
	task automatic t_paging();
		wr_file(7'h0a, 8'h18);
		wr_file(7'h02, 8'h45);
		#1 chk_pc(pc, 13'h1845);
		rd_file(7'h0a, d);
		chk_d(d, 8'h18);
		do_op(PC_JUMP, 11'h123);
		chk_pc(pc, 13'h1923);
		do_op(PC_STEP, 11'h0);
		chk_pc(pc, 13'h1924);
	endtask
	task automatic t_stack();
		logic [12:0] slot [8];
		logic [12:0] cur;
		cur = pc;
		// nine pushes: the last one lands on the slot of the first
		for (int k = 0; k < 9; k++) begin
			slot[k[2:0]] = cur + 13'h1;
			do_op(k == 0 ? PC_VECT : PC_CALL, 11'(k * 16));
			cur = (k == 0) ? 13'h0abc : {2'b11, 11'(k * 16)};
			chk_pc(pc, cur);
		end
		wr_file(7'h0a, 8'h00);
		for (int j = 0; j < 9; j++) begin
			do_op(PC_RET, 11'h0);
			chk_pc(pc, slot[3'(8 - j)]);
		end
		rd_file(7'h0a, d);
		chk_d(d, 8'h00);
	endtask
	task automatic t_indirect();
		@(posedge clk);
		bank <= 1'b1;
		wr_file(7'h04, 8'h20);
		wr_file(7'h00, 8'h5a);
		@(posedge clk);
		#1 chk_d(ram.mem[9'h120], 8'h5a);
		rd_file(7'h00, d);
		chk_d(d, 8'h5a);
		wr_file(7'h04, 8'h00);
		wr_file(7'h00, 8'h77);
		#1 chk_d({7'h00, rwr}, 8'h00);
		rd_file(7'h00, d);
		chk_d(d, 8'h00);
		rd_file(7'h7f, d);
		chk_d(d, 8'h00);
	endtask
	task automatic t_reset();
		@(posedge clk);
		srst <= 1'b1;
		@(posedge clk);
		srst <= 1'b0;
		#1 chk_pc(pc, 13'h0000);
	endtask
	task automatic end_sim();
		$display("mismatches %0d compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge clk);
		srst <= 1'b0;
		#1 chk_pc(pc, 13'h0000);
		chk_d(latch, 8'h00);
		t_paging();
		t_stack();
		t_indirect();
		t_reset();
		end_sim();
	end
	// whole run needs well under a thousand cycles
	initial begin
		#20000;
		n_mismatch++;
		end_sim();
	end
endmodule
